// [inc/rsh_pkg.sv]
// Purpose: Constants for the serial host port with reset and interface watchdog
// Assumes: Register indices 00h to 0Fh, one byte each
// Notes:   Reset values cover the control bits only; time bits hold their content
package rsh_pkg;
  localparam logic [3:0] RSH_IDX_CTRL1    = 4'h0;
  localparam logic [3:0] RSH_IDX_CTRL2    = 4'h1;
  localparam logic [3:0] RSH_IDX_SECONDS  = 4'h2;
  localparam logic [3:0] RSH_IDX_MINUTES  = 4'h3;
  localparam logic [3:0] RSH_IDX_HOURS    = 4'h4;
  localparam logic [3:0] RSH_IDX_DAYS     = 4'h5;
  localparam logic [3:0] RSH_IDX_WEEKDAYS = 4'h6;
  localparam logic [3:0] RSH_IDX_MONTHS   = 4'h7;
  localparam logic [3:0] RSH_IDX_YEARS    = 4'h8;
  localparam logic [3:0] RSH_IDX_AL_MIN   = 4'h9;
  localparam logic [3:0] RSH_IDX_AL_HOUR  = 4'ha;
  localparam logic [3:0] RSH_IDX_AL_DAY   = 4'hb;
  localparam logic [3:0] RSH_IDX_AL_WDAY  = 4'hc;
  localparam logic [3:0] RSH_IDX_CLKSEL   = 4'hd;
  localparam logic [3:0] RSH_IDX_CD_SETUP = 4'he;
  localparam logic [3:0] RSH_IDX_CD_VALUE = 4'hf;
  localparam logic [3:0] RSH_IDX_LAST     = 4'hf;
  localparam int         RSH_NUM_REGS     = 16;
  // Implemented-bit masks per register
  localparam logic [7:0] RSH_MASK [RSH_NUM_REGS] = '{
    8'hec, 8'hff, 8'hff, 8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h1f,
    8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h07, 8'h83, 8'hff};
  // Control bits forced at every internal reset, and their values
  localparam logic [7:0] RSH_RSTM [RSH_NUM_REGS] = '{
    8'hec, 8'hff, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h07, 8'h83, 8'h00};
  localparam logic [7:0] RSH_RSTV [RSH_NUM_REGS] = '{
    8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h03, 8'h00};
  localparam int         RSH_FLAG_BIT     = 7;   // Oscillator-stop flag in seconds
  localparam int         RSH_ARM_BIT      = 3;   // Reset-bypass arm in control_one
  localparam int         RSH_HOUR12_BIT   = 2;   // 12-hour select in control_one
  localparam int         RSH_RW_BIT       = 7;
  localparam logic [2:0] RSH_SUBADDR      = 3'b001;
  localparam logic [2:0] RSH_CLKSEL_32K   = 3'b000;
  localparam int         RSH_WDOG_TICKS   = 2;
  localparam int         RSH_CLK_HZ       = 125000000;
  localparam int         RSH_FIFO_DEPTH   = 8;
  // Bypass sequence: minimum hold of each phase
  localparam int         RSH_BYP_MIN_NS   = 500;
  localparam int         RSH_BYP_MIN_CYC  = (RSH_BYP_MIN_NS * 125 + 999) / 1000;
  typedef enum logic [3:0] {
    RSH_ST_CMD  = 4'b0001,
    RSH_ST_WR   = 4'b0010,
    RSH_ST_RD   = 4'b0100,
    RSH_ST_IGN  = 4'b1000
  } rsh_state_type;
endpackage : rsh_pkg

// [design/rsh_serial_port.sv]
// Purpose: Serial host port of a clock chip: command decode, register file, freeze, watchdog
// Assumes: Link pins are asynchronous and sampled twice; i_osc_running is a level from the oscillator
// Notes:   Write bytes pass an internal FIFO before they reach the register file
// Contract
// - Hold logic reset while oscillator stopped
// - Every internal reset sets oscillator-stop flag
// - Unimplemented register bits read zero; the code zeroes them only on a write, not at reset
// - Time bits keep content over resets
// - Reset selects 32k output, arm, 24h
// - Chip enable low reinitialises interface
// - Bypass needs arm bit and pin sequence
// - Bypass entry releases internal reset immediately
// - Writing arm zero leaves bypass mode
// - Transfer active only while enable high
// - Input sampled on serial clock rise
// - Output changes on serial clock fall
// - Bytes are eight bits, MSB first
// - First byte is command, rest data
// - Command bit 7 selects read/write
// - Subaddress must be 001 else ignore
// - Command low nibble is start index
// - Index increments, wraps after 0Fh
// - Time counting frozen during access
// - Watchdog aborts access stuck over 1s
// - Enable must drop low after abort
// - Abort within 1-2s, losing one second
`timescale 1ns/10ps

module rsh_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             push;
  logic             pop;

  // Full and empty from pointer comparison with wrap bit
  assign o_in_ready  = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
  assign o_out_valid = (wp_r != rp_r);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_r[rp_r[AW-1:0]];

  // Storage array
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (i_flush) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule : rsh_fifo

module rsh_serial_port
  import rsh_pkg::*;
#(
  parameter int BYP_MIN_CYC = RSH_BYP_MIN_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_osc_running,
  input  wire logic       i_tick_1hz,
  input  wire logic       i_chip_enable,
  input  wire logic       i_serial_clock,
  input  wire logic       i_serial_data_in,
  input  wire logic       i_reg_stall,
  output logic            o_serial_data_out,
  output logic            o_serial_data_out_en,
  output logic            o_internal_reset,
  output logic            o_freeze,
  output logic            o_tick_gated,
  output logic            o_hour12,
  output logic [2:0]      o_clock_output_pin_select,
  output logic            o_bypass_active
);
  // Pin synchronisers
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic       ce;
  logic       sck;
  logic       serial_data_in;
  logic       sck_d_r;
  logic       osc1_r;
  logic       osc2_r;
  logic       sck_rise;
  logic       sck_fall;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_r    <= 3'h0;
      s2_r    <= 3'h0;
      sck_d_r <= 1'b0;
      osc1_r  <= 1'b0;
      osc2_r  <= 1'b0;
    end else begin
      s1_r    <= {i_chip_enable, i_serial_clock, i_serial_data_in};
      s2_r    <= s1_r;
      sck_d_r <= s2_r[1];
      osc1_r  <= i_osc_running;
      osc2_r  <= osc1_r;
    end
  end

  assign ce       = s2_r[2];
  assign sck      = s2_r[1];
  assign serial_data_in      = s2_r[0];
  assign sck_rise = ce && sck && !sck_d_r;
  assign sck_fall = ce && !sck && sck_d_r;

  // Register file and bypass state
  logic [7:0]    regs_r [RSH_NUM_REGS];
  logic          bypass_r;
  logic          int_rst;
  logic          int_rst_d_r;
  logic          fifo_valid;
  logic          fifo_ready;
  logic [11:0]   fifo_data;
  logic          wr_take;
  logic          clr_arm;

  // bypass lifts the reset at once
  assign int_rst          = !osc2_r && !bypass_r;
  assign o_internal_reset = int_rst;
  assign o_bypass_active  = bypass_r;
  assign wr_take          = fifo_valid && !i_reg_stall && !int_rst;
  assign clr_arm          = wr_take && (fifo_data[11:8] == RSH_IDX_CTRL1) && !fifo_data[RSH_ARM_BIT];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_rst_d_r <= 1'b1;
    end else begin
      int_rst_d_r <= int_rst;
    end
  end

  // Bypass sequence: with enable low, data in high then low then enable pulses high
  logic [1:0]  byp_ph_r;
  logic [15:0] byp_cnt_r;
  logic        sdi_d_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sdi_d_r <= 1'b0;
    end else begin
      sdi_d_r <= serial_data_in;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      byp_ph_r  <= 2'h0;
      byp_cnt_r <= 16'h0;
    end else if (!regs_r[RSH_IDX_CTRL1][RSH_ARM_BIT] || bypass_r || (ce && byp_ph_r != 2'h2)
                 || (serial_data_in != sdi_d_r && byp_cnt_r < 16'(BYP_MIN_CYC))) begin
      byp_ph_r  <= 2'h0;
      byp_cnt_r <= 16'h0;
    end else if (serial_data_in != sdi_d_r) begin
      byp_ph_r  <= (serial_data_in == byp_ph_r[0]) ? 2'h0 : 2'(byp_ph_r + 2'h1);
      byp_cnt_r <= 16'h0;
    end else if (byp_cnt_r != 16'hffff) begin
      byp_cnt_r <= byp_cnt_r + 16'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bypass_r <= 1'b0;
    end else if (clr_arm) begin
      bypass_r <= 1'b0;
    end else if (byp_ph_r == 2'h2 && ce && byp_cnt_r >= 16'(BYP_MIN_CYC)) begin
      bypass_r <= 1'b1;
    end
  end

  // Register storage: control bits reset, time bits kept
  genvar gi;
  generate
    for (gi = 0; gi < RSH_NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge i_clk) begin
        // reset values select 32k, arm, 24h
        if (int_rst) begin
          regs_r[gi] <= (regs_r[gi] & ~RSH_RSTM[gi]) | RSH_RSTV[gi];
        end else if (int_rst_d_r && gi == RSH_IDX_SECONDS) begin
          regs_r[gi] <= regs_r[gi] | 8'h80;
        end else if (wr_take && fifo_data[11:8] == 4'(gi)) begin
          regs_r[gi] <= fifo_data[7:0] & RSH_MASK[gi];
        end
      end
    end
  endgenerate

  assign o_hour12        = regs_r[RSH_IDX_CTRL1][RSH_HOUR12_BIT];
  assign o_clock_output_pin_select = regs_r[RSH_IDX_CLKSEL][2:0];

  // Serial engine
  rsh_state_type st_r;
  logic [2:0]    bit_r;
  logic [7:0]    shin_r;
  logic [7:0]    shout_r;
  logic [3:0]    idx_r;
  logic          byte_done;
  logic [7:0]    byte_in;
  logic          abort_r;
  logic [1:0]    wd_cnt_r;
  logic          access;
  logic          push_req;
  logic          pend_r;

  assign byte_in   = {shin_r[6:0], serial_data_in};
  assign byte_done = sck_rise && bit_r == 3'h7;
  assign push_req  = byte_done && st_r == RSH_ST_WR;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r   <= RSH_ST_CMD;
      bit_r  <= 3'h0;
      shin_r <= 8'h0;
      idx_r  <= 4'h0;
    end else if (!ce || int_rst) begin
      st_r   <= RSH_ST_CMD;
      bit_r  <= 3'h0;
      shin_r <= 8'h0;
      idx_r  <= 4'h0;
    end else if (abort_r) begin
      st_r <= RSH_ST_IGN;
    end else if (sck_rise) begin
      shin_r <= byte_in;
      bit_r  <= bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        case (st_r)
          RSH_ST_CMD: begin
            if (byte_in[6:4] != RSH_SUBADDR) begin
              st_r <= RSH_ST_IGN;
            end else begin
              st_r <= byte_in[RSH_RW_BIT] ? RSH_ST_RD : RSH_ST_WR;
            end
            idx_r <= byte_in[3:0];
          end
          RSH_ST_WR: idx_r <= (idx_r == RSH_IDX_LAST) ? 4'h0 : idx_r + 4'h1;
          RSH_ST_RD: idx_r <= (idx_r == RSH_IDX_LAST) ? 4'h0 : idx_r + 4'h1;
          RSH_ST_IGN: idx_r <= idx_r;
          default: st_r <= RSH_ST_IGN;
        endcase
      end
    end
  end

  // Write bytes buffered as index and data
  rsh_fifo #(
    .WIDTH (12),
    .DEPTH (RSH_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_flush     (int_rst),
    .i_in_valid  (push_req),
    .o_in_ready  (fifo_ready),
    .i_in_data   ({idx_r, byte_in}),
    .o_out_valid (fifo_valid),
    .i_out_ready (!i_reg_stall && !int_rst),
    .o_out_data  (fifo_data)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shout_r              <= 8'h0;
      o_serial_data_out    <= 1'b0;
      o_serial_data_out_en <= 1'b0;
    end else if (st_r != RSH_ST_RD || !ce || abort_r) begin
      shout_r              <= 8'h0;
      o_serial_data_out    <= 1'b0;
      o_serial_data_out_en <= 1'b0;
    end else if (sck_fall) begin
      o_serial_data_out_en <= 1'b1;
      if (bit_r == 3'h0) begin
        o_serial_data_out <= regs_r[idx_r][7];
        shout_r           <= {regs_r[idx_r][6:0], 1'b0};
      end else begin
        o_serial_data_out <= shout_r[7];
        shout_r           <= {shout_r[6:0], 1'b0};
      end
    end
  end

  assign access       = ce && (st_r == RSH_ST_WR || st_r == RSH_ST_RD) && !abort_r;
  assign o_freeze     = access;
  // a tick during an access is held and let out after it, so an abort costs one second
  assign o_tick_gated = (i_tick_1hz || pend_r) && !access && !int_rst;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wd_cnt_r <= 2'h0;
      abort_r  <= 1'b0;
      pend_r   <= 1'b0;
    end else if (!ce) begin
      wd_cnt_r <= 2'h0;
      abort_r  <= 1'b0;
      pend_r   <= 1'b0;
    end else if (access && i_tick_1hz) begin
      wd_cnt_r <= wd_cnt_r + 2'h1;
      pend_r   <= 1'b1;
      if (wd_cnt_r == 2'(RSH_WDOG_TICKS - 1)) begin
        abort_r <= 1'b1;
      end
    end else if (!access) begin
      pend_r <= 1'b0;
    end
  end

  // No back-pressure: a write byte that arrives while the FIFO is full is dropped; fifo_ready is left unused
  logic unused_ready;
  assign unused_ready = fifo_ready;
endmodule : rsh_serial_port

// [test/rsh_host_model.sv]
// Purpose: Behavioural serial host that frames bytes for the port
// Assumes: Link clock period 160 ns; pins change at the falling edge of i_clk
// Notes:   Link clock stands low between frames; data line flips when released
`timescale 1ns/10ps
module rsh_host_model (
  input  wire logic i_clk,
  input  wire logic i_serial_data_out,
  output logic      o_chip_enable,
  output logic      o_serial_clock,
  output logic      o_serial_data_in
);
  localparam int HALF = 10;  // Half link period in clocks

  // Idle pins at time zero
  initial begin
    o_chip_enable = 1'b0;
    o_serial_clock = 1'b0;
    o_serial_data_in = 1'b0;
  end

  task start_frame();
    @(negedge i_clk);
    o_chip_enable = 1'b1;
    repeat (HALF) @(negedge i_clk);
  endtask : start_frame

  // set while low, sample before rise
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      o_serial_clock = 1'b0;
      o_serial_data_in = tx[b];
      repeat (HALF) @(negedge i_clk);
      rx[b] = i_serial_data_out;
      o_serial_clock = 1'b1;
      repeat (HALF) @(negedge i_clk);
    end
  endtask : xfer

  task end_frame();
    o_serial_clock = 1'b0;
    repeat (HALF) @(negedge i_clk);
    o_chip_enable = 1'b0;
    o_serial_data_in = ~o_serial_data_in;
    repeat (2 * HALF) @(negedge i_clk);
  endtask : end_frame

  // bypass pin sequence
  // Enable low: data high, then low, then a short enable pulse; phases sized for the bench minimum
  task bypass_seq();
    o_serial_data_in = 1'b0;
    repeat (HALF) @(negedge i_clk);
    o_serial_data_in = 1'b1;
    repeat (HALF) @(negedge i_clk);
    o_serial_data_in = 1'b0;
    repeat (HALF) @(negedge i_clk);
    o_chip_enable = 1'b1;
    repeat (HALF) @(negedge i_clk);
    o_chip_enable = 1'b0;
    repeat (HALF) @(negedge i_clk);
  endtask : bypass_seq
endmodule : rsh_host_model

// [test/rsh_serial_port_properties.sv]
// Purpose: Port-level checks of the serial host port
// Assumes: One clock domain, pins synchronised within a few cycles
// Notes:   Sync latency bounds are generous on purpose
`timescale 1ns/10ps
module rsh_serial_port_properties #(
  parameter int BYP_MIN_CYC = 4
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_osc_running,
  input wire logic       i_tick_1hz,
  input wire logic       i_chip_enable,
  input wire logic       i_serial_clock,
  input wire logic       o_serial_data_out,
  input wire logic       o_serial_data_out_en,
  input wire logic       o_internal_reset,
  input wire logic       o_freeze,
  input wire logic       o_tick_gated,
  input wire logic       o_hour12,
  input wire logic [2:0] o_clock_output_pin_select,
  input wire logic       o_bypass_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [1:0] ticks_r;
  logic       pend_m_r;

  // Ticks seen while an access is frozen
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) ticks_r <= 2'h0;
    else if (!o_freeze) ticks_r <= 2'h0;
    else if (i_tick_1hz && ticks_r != 2'h2) ticks_r <= ticks_r + 2'h1;
  end

  // Tick held back during an access, due once the access ends
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) pend_m_r <= 1'b0;
    else if (o_freeze && i_tick_1hz) pend_m_r <= 1'b1;
    else if (!o_freeze) pend_m_r <= 1'b0;
  end

  sequence s_ce_gone;
    !i_chip_enable [*5];
  endsequence
  sequence s_osc_gone;
    !i_osc_running [*4];
  endsequence

  AST_OUT_EN_CE: assert property (s_ce_gone |-> !o_serial_data_out_en)
    else $error("data out driven with enable low");
  AST_FREEZE_CE: assert property (s_ce_gone |-> !o_freeze)
    else $error("freeze held with enable low");
  AST_TICK_HELD: assert property (o_freeze |-> !o_tick_gated)
    else $error("tick passed during access");
  AST_TICK_SRC: assert property (o_tick_gated |-> i_tick_1hz || pend_m_r)
    else $error("tick without source tick");
  AST_TICK_PASS: assert property (i_tick_1hz && !o_freeze && !o_internal_reset |-> o_tick_gated)
    else $error("idle tick swallowed");
  AST_OSC_RESET: assert property (s_osc_gone ##0 !o_bypass_active |-> o_internal_reset)
    else $error("no internal reset with oscillator stopped");
  AST_RESET_MODE: assert property (o_internal_reset |=> o_clock_output_pin_select == 3'h0 && !o_hour12)
    else $error("reset mode not selected");
  AST_SDO_FALL: assert property (o_serial_data_out_en && $past(o_serial_data_out_en)
    && $changed(o_serial_data_out) |-> !i_serial_clock)
    else $error("data out changed while link clock high");
  AST_WDOG: assert property (ticks_r == 2'd2 |-> ##[0:3] !o_freeze)
    else $error("access not aborted after second tick");
  AST_TICK_LATE: assert property (pend_m_r && !o_freeze && !o_internal_reset |-> o_tick_gated)
    else $error("held tick not released after access");
  AST_BYP_REL: assert property (o_bypass_active |-> !o_internal_reset)
    else $error("internal reset held in bypass mode");
endmodule : rsh_serial_port_properties

bind rsh_serial_port rsh_serial_port_properties #(.BYP_MIN_CYC(BYP_MIN_CYC)) chk_u (.*);

// [test/rsh_serial_port_test.sv]
// Purpose: Self-checking bench of the serial host port
// Assumes: Host model drives the link pins; ticks pulsed by hand
// Notes:   Time bits are checked only after being written
`timescale 1ns/10ps
module rsh_serial_port_test;
  import rsh_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_osc_running = 1'b1;
  logic       i_tick_1hz = 1'b0;
  logic       i_reg_stall = 1'b0;
  logic       ce, sclk, serial_data_in, serial_data_out, sdo_en, int_rst, freeze, tick_g, hour12, bypass;
  logic [2:0] clk_sel;
  logic [7:0] got [0:7];
  logic [7:0] rx;
  int         mismatches = 0;
  int         tests_run = 0;

  always #4 i_clk = ~i_clk;

  rsh_host_model host_u (.i_clk(i_clk), .i_serial_data_out(serial_data_out), .o_chip_enable(ce),
    .o_serial_clock(sclk), .o_serial_data_in(serial_data_in));
  rsh_serial_port #(.BYP_MIN_CYC(4)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_osc_running(i_osc_running), .i_tick_1hz(i_tick_1hz), .i_chip_enable(ce),
    .i_serial_clock(sclk), .i_serial_data_in(serial_data_in), .i_reg_stall(i_reg_stall),
    .o_serial_data_out(serial_data_out), .o_serial_data_out_en(sdo_en), .o_internal_reset(int_rst),
    .o_freeze(freeze), .o_tick_gated(tick_g), .o_hour12(hour12),
    .o_clock_output_pin_select(clk_sel), .o_bypass_active(bypass));

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Command then n data bytes taken from the top of wd
  task frame(input logic [7:0] cmd, input logic [63:0] wd, input int n);
    host_u.start_frame();
    host_u.xfer(cmd, rx);
    for (int i = 0; i < n; i++) host_u.xfer(wd[63-8*i -: 8], got[i]);
    host_u.end_frame();
  endtask : frame

  task pulse(input logic exp);
    @(negedge i_clk);
    i_tick_1hz = 1'b1;
    #1 check("tick_gated", {7'h0, tick_g}, {7'h0, exp});
    @(negedge i_clk);
    i_tick_1hz = 1'b0;
  endtask : pulse

  task s_reset();
    frame(8'h90, 64'h0, 2);
    check("ctrl1", got[0], 8'h08);
    check("ctrl2", got[1], 8'h00);
    check("sel", {5'h0, clk_sel}, 8'h00);
    check("h12", {7'h0, hour12}, 8'h00);
    check("sdo_idle", {7'h0, sdo_en}, 8'h00);
    pulse(1'b1);
  endtask : s_reset

  task s_wrap();
    i_reg_stall = 1'b1;
    frame(8'h1d, 64'hffffa50400150000, 6);
    i_reg_stall = 1'b0;
    repeat (10) @(negedge i_clk);
    frame(8'h9d, 64'h0, 6);
    check("clksel", got[0], 8'h07);
    check("cdset", got[1], 8'h83);
    check("cdval", got[2], 8'ha5);
    check("ctrl1w", got[3], 8'h04);
    check("secw", got[5], 8'h15);
    check("sel7", {5'h0, clk_sel}, 8'h07);
    check("h12w", {7'h0, hour12}, 8'h01);
  endtask : s_wrap

  task s_badsub();
    for (int c = 0; c < 8; c++) begin
      if (c != 1) frame({1'b0, c[2:0], 4'h2}, 64'h7700000000000000, 1);
    end
    frame(8'h92, 64'h0, 1);
    check("sec_kept", got[0], 8'h15);
  endtask : s_badsub

  task s_wdog();
    host_u.start_frame();
    host_u.xfer(8'h12, rx);
    repeat (8) @(negedge i_clk);
    check("frz", {7'h0, freeze}, 8'h01);
    pulse(1'b0);
    check("frz1", {7'h0, freeze}, 8'h01);
    pulse(1'b0);
    #1 check("tick_late", {7'h0, tick_g}, 8'h01);
    repeat (4) @(negedge i_clk);
    check("frz2", {7'h0, freeze}, 8'h00);
    host_u.xfer(8'h33, rx);
    host_u.end_frame();
    frame(8'h92, 64'h0, 1);
    check("sec_abort", got[0], 8'h15);
  endtask : s_wdog

  task s_osc();
    i_osc_running = 1'b0;
    repeat (8) @(negedge i_clk);
    check("irst", {7'h0, int_rst}, 8'h01);
    pulse(1'b0);
    i_osc_running = 1'b1;
    repeat (8) @(negedge i_clk);
    frame(8'h90, 64'h0, 3);
    check("ctrl1r", got[0], 8'h08);
    check("sec_flag", got[2], 8'h95);
    check("sel0", {5'h0, clk_sel}, 8'h00);
  endtask : s_osc

  task s_bypass();
    i_osc_running = 1'b0;
    repeat (8) @(negedge i_clk);
    host_u.bypass_seq();
    check("byp_on", {7'h0, bypass}, 8'h01);
    check("byp_irst", {7'h0, int_rst}, 8'h00);
    frame(8'h10, 64'h0, 1);
    check("byp_off", {7'h0, bypass}, 8'h00);
    check("byp_irst1", {7'h0, int_rst}, 8'h01);
    i_osc_running = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask : s_bypass

  task final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #300000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (12) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (5) @(negedge i_clk);
    s_reset();
    s_wrap();
    s_badsub();
    s_wdog();
    s_osc();
    s_bypass();
    final_report();
  end
endmodule : rsh_serial_port_test
